// ### logic/ddr2_cmd_pkg.sv
// Shared constants, command carrier and bank state type for the bank tracker
package ddr2_cmd_pkg;

  // ==========================================================
  // Geometry
  localparam int BA_W      = 2;
  localparam int ADDR_W    = 14;
  localparam int NUM_BANKS = 4;
  localparam int AP_BIT    = 10;  // Auto precharge / all-bank select bit
  localparam int TMR_W     = 8;

  // ==========================================================
  // Timing, in ns or clocks as printed, and derived clock counts
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_RCD_NS      = 15;
  localparam int T_RP_NS       = 15;
  localparam int T_WR_NS       = 15;
  localparam int T_RFC_NS      = 105;
  localparam int T_MRD_CK      = 2;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WR_CYC  = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] ROW_RST  = 14'h0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } cmd_s;

  typedef enum logic [2:0] {
    BANK_IDLE,
    BANK_OPENING,
    BANK_ACTIVE,
    BANK_READ,
    BANK_WRITE,
    BANK_READ_AP,
    BANK_WRITE_AP,
    BANK_CLOSING
  } bank_state_e;

endpackage

// ### logic/ddr2_bank_tracker.sv
// Command decoder and per-bank state tracker of a four-bank DDR2 device
//
// Behaviour
// [R1] CS high: no new command taken, running operations continue.
// [R2] CS low, RAS/CAS/WE high is a no-operation; nothing new starts.
// [R3] RAS/CAS/WE: LHH activate, HLH read, HLL write, LHL precharge.
// [R4] Controller applies bank rules only with CKE high on two edges.
// [R5] Controller may send bank m anything it allows while bank n idles.
// [R6] Controller may send activate/read/write/precharge to other bank while n busy.
// [R7] Idle after precharge, tRP and read burst; active after tRCD.
// [R8] Read/write state lasts from non-auto-precharge burst start to its end.
// [R9] Read auto precharge: precharge begins at earliest legal precharge point.
// [R10] Write auto precharge: precharge begins when tWR ends.
// [R11] Other banks take commands during auto precharge without disturbing data.
// [R12] Controller refreshes or loads mode only with all banks idle.
// [R13] Controller delays writes until another bank's read burst completes.
// [R14] Read after write waits the larger of two clocks and tWTR.
// [R15] After write AP: read waits CL-1+BL/2+tWTR, write waits BL/2.
// [R16] After read AP: read waits BL/2, write waits BL/2+2 clocks.
// [R17] After any AP access, precharge/activate elsewhere needs one clock.
// [R18] Controller never creates unlisted state and command combinations.
// [R19] Mode load: bank address picks the register, address gives contents.
// [R20] Controller issues nothing executable until tMRD after mode load.
// [R21] Activate opens addressed row in addressed bank until precharged.
// [R22] Controller precharges before opening another row in same bank.
// [R23] A10 on read or write selects auto precharge at burst end.
// [R24] Controller keeps per-bank state and countdowns to check commands.
`timescale 1ns/1ns

module ddr2_bank_tracker
#(
  parameter int BURST_LEN = 4,
  parameter int CAS_LAT   = 5
)
(
  input  wire logic                                           mclk,
  input  wire logic                                           reset_n,
  input  wire ddr2_cmd_pkg::cmd_s                             cmd,
  output ddr2_cmd_pkg::bank_state_e [ddr2_cmd_pkg::NUM_BANKS-1:0] bank_state,
  output logic [ddr2_cmd_pkg::NUM_BANKS-1:0][ddr2_cmd_pkg::ADDR_W-1:0] open_row,
  output logic [ddr2_cmd_pkg::NUM_BANKS-1:0][ddr2_cmd_pkg::ADDR_W-1:0] mode_reg,
  output logic                                                ref_busy_q,
  output logic                                                mrd_busy_q,
  output logic                                                cmd_accepted_q,
  output logic                                                cmd_illegal_q
);

  localparam int NB = ddr2_cmd_pkg::NUM_BANKS;
  localparam int TW = ddr2_cmd_pkg::TMR_W;
  localparam int AW = ddr2_cmd_pkg::ADDR_W;
  localparam int RD_AP_CYC = BURST_LEN / 2;
  localparam int WR_AP_CYC = CAS_LAT - 1 + BURST_LEN / 2 + ddr2_cmd_pkg::T_WR_CYC;
  localparam int RCD_CYC   = ddr2_cmd_pkg::T_RCD_CYC;
  localparam logic [TW-1:0] RCD_LD   = TW'(ddr2_cmd_pkg::T_RCD_CYC - 1);
  localparam logic [TW-1:0] RP_LD    = TW'(ddr2_cmd_pkg::T_RP_CYC - 1);
  localparam logic [TW-1:0] RFC_LD   = TW'(ddr2_cmd_pkg::T_RFC_CYC - 1);
  localparam logic [TW-1:0] MRD_LD   = TW'(ddr2_cmd_pkg::T_MRD_CK - 1);
  localparam logic [TW-1:0] RD_BS_LD = TW'(CAS_LAT + BURST_LEN / 2 - 1);
  localparam logic [TW-1:0] WR_BS_LD = TW'(CAS_LAT - 1 + BURST_LEN / 2 - 1);
  localparam logic [TW-1:0] RDAP_LD  = TW'(RD_AP_CYC - 1);
  localparam logic [TW-1:0] WRAP_LD  = TW'(WR_AP_CYC - 1);

  // ==========================================================
  // Parameter checks
  if (!(BURST_LEN == 4 || BURST_LEN == 8))
  begin : g_bl_check
    $error("burst length must be 4 or 8");
  end
  if (CAS_LAT < 3 || CAS_LAT > 7)
  begin : g_cl_check
    $error("CAS latency must be 3 to 7");
  end
  // The opening check below counts two cycles in its repetition
  if (RCD_CYC != 2)
  begin : g_rcd_check
    $error("tRCD must be two clocks");
  end

  // ==========================================================
  // Command decode
  logic cke_q;
  logic [TW-1:0] ref_tm_q;
  logic [TW-1:0] mrd_tm_q;
  logic [NB-1:0] is_idle;
  logic [NB-1:0] is_quiet;
  logic [NB-1:0] rw_ok;
  logic [NB-1:0] pre_ok;

  // Commands count only with CKE high on this and the previous edge
  wire cmd_en  = cke_q & cmd.cke & ~cmd.cs_n;                          // see [R1]
  wire is_nop  = cmd_en & cmd.ras_n & cmd.cas_n & cmd.we_n;            // see [R2]
  wire is_act  = cmd_en & ~cmd.ras_n & cmd.cas_n & cmd.we_n;           // see [R3]
  wire is_rd   = cmd_en & cmd.ras_n & ~cmd.cas_n & cmd.we_n;           // see [R3]
  wire is_wr   = cmd_en & cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;          // see [R3]
  wire is_pre  = cmd_en & ~cmd.ras_n & cmd.cas_n & ~cmd.we_n;          // see [R3]
  wire is_ref  = cmd_en & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
  wire is_lm   = cmd_en & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
  wire ap_sel  = cmd.addr[ddr2_cmd_pkg::AP_BIT];                       // see [R23]
  wire busy    = ref_busy_q | mrd_busy_q;

  // Legality against the addressed bank, or all banks for refresh, mode load and precharge all; a busy device refuses everything
  wire ok_act  = is_act & is_idle[cmd.ba] & ~busy;
  wire ok_rd   = is_rd & rw_ok[cmd.ba] & ~busy;                        // see [R11]
  wire ok_wr   = is_wr & rw_ok[cmd.ba] & ~busy;                        // see [R11]
  wire ok_pre  = is_pre & ~busy & (ap_sel ? (&pre_ok) : pre_ok[cmd.ba]);
  wire ok_ref  = is_ref & (&is_quiet) & ~busy;
  wire ok_lm   = is_lm & (&is_quiet) & ~busy;
  wire accept  = ok_act | ok_rd | ok_wr | ok_pre | ok_ref | ok_lm;
  wire exec    = cmd_en & ~is_nop;

  // ==========================================================
  // Global timers and status
  // Busy flags are registered so they stand exactly tRFC or tMRD clocks
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cke_q          <= 1'b0;
      ref_tm_q       <= '0;
      mrd_tm_q       <= '0;
      ref_busy_q     <= 1'b0;
      mrd_busy_q     <= 1'b0;
      cmd_accepted_q <= 1'b0;
      cmd_illegal_q  <= 1'b0;
    end
    else
    begin
      cke_q          <= cmd.cke;
      ref_tm_q       <= ok_ref ? RFC_LD : (ref_tm_q != '0 ? ref_tm_q - 1'b1 : '0);
      mrd_tm_q       <= ok_lm ? MRD_LD : (mrd_tm_q != '0 ? mrd_tm_q - 1'b1 : '0);
      ref_busy_q     <= ok_ref | (ref_busy_q & (ref_tm_q != '0));
      mrd_busy_q     <= ok_lm | (mrd_busy_q & (mrd_tm_q != '0));
      cmd_accepted_q <= accept;                                        // see [R1]
      cmd_illegal_q  <= exec & ~accept;
    end
  end

  // ==========================================================
  // Mode registers, one per bank address value
  genvar m;
  for (m = 0; m < NB; m++)
  begin : g_mode
    logic [AW-1:0] mode_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
        mode_q <= ddr2_cmd_pkg::MODE_RST;
      else if (ok_lm && cmd.ba == m)                                   // see [R19]
        mode_q <= cmd.addr;
    end
    assign mode_reg[m] = mode_q;
  end

  // ==========================================================
  // Per-bank state machines
  ddr2_cmd_pkg::bank_state_e st_q [NB];
  logic [TW-1:0] tm_q [NB];
  logic [TW-1:0] bs_q [NB];
  logic [AW-1:0] row_q [NB];

  genvar b;
  for (b = 0; b < NB; b++)
  begin : g_bank
    ddr2_cmd_pkg::bank_state_e st_d;
    logic [TW-1:0] tm_d;
    logic [TW-1:0] bs_d;
    logic [AW-1:0] row_d;
    wire sel    = (cmd.ba == b);
    wire go_act = ok_act & sel;
    wire go_rd  = ok_rd & sel;
    wire go_wr  = ok_wr & sel;
    wire go_pre = ok_pre & (sel | ap_sel);
    wire tm_end = (tm_q[b] == '0);
    wire bs_end = (bs_q[b] == '0);

    // Classification used by the decoder; AP states refuse same-bank commands
    assign is_idle[b]  = (st_q[b] == ddr2_cmd_pkg::BANK_IDLE);
    assign is_quiet[b] = is_idle[b] & bs_end;
    assign rw_ok[b]    = (st_q[b] == ddr2_cmd_pkg::BANK_ACTIVE)
                       | (st_q[b] == ddr2_cmd_pkg::BANK_READ)
                       | (st_q[b] == ddr2_cmd_pkg::BANK_WRITE);
    assign pre_ok[b]   = rw_ok[b] | is_idle[b]
                       | (st_q[b] == ddr2_cmd_pkg::BANK_CLOSING);

    // Timer counts the current phase; burst counter tracks data on the pins
    always_comb
    begin
      st_d  = st_q[b];
      tm_d  = tm_end ? '0 : tm_q[b] - 1'b1;
      bs_d  = bs_end ? '0 : bs_q[b] - 1'b1;
      row_d = row_q[b];
      unique case (st_q[b])
        ddr2_cmd_pkg::BANK_IDLE:
          if (go_act)
          begin
            st_d  = ddr2_cmd_pkg::BANK_OPENING;                        // see [R21]
            tm_d  = RCD_LD;
            row_d = cmd.addr;                                          // see [R21]
          end
        ddr2_cmd_pkg::BANK_OPENING:
          if (tm_end)
            st_d = ddr2_cmd_pkg::BANK_ACTIVE;                          // see [R7]
        ddr2_cmd_pkg::BANK_ACTIVE,
        ddr2_cmd_pkg::BANK_READ,
        ddr2_cmd_pkg::BANK_WRITE:
          if (go_pre)
          begin
            st_d = ddr2_cmd_pkg::BANK_CLOSING;
            tm_d = RP_LD;
          end
          else if (go_rd)
          begin
            st_d = ap_sel ? ddr2_cmd_pkg::BANK_READ_AP : ddr2_cmd_pkg::BANK_READ; // see [R23]
            tm_d = RDAP_LD;                                            // see [R9]
            bs_d = RD_BS_LD;
          end
          else if (go_wr)
          begin
            st_d = ap_sel ? ddr2_cmd_pkg::BANK_WRITE_AP : ddr2_cmd_pkg::BANK_WRITE; // see [R23]
            tm_d = WRAP_LD;                                            // see [R10]
            bs_d = WR_BS_LD;
          end
          else if (st_q[b] != ddr2_cmd_pkg::BANK_ACTIVE && bs_end)
            st_d = ddr2_cmd_pkg::BANK_ACTIVE;                          // see [R8]
        ddr2_cmd_pkg::BANK_READ_AP,
        ddr2_cmd_pkg::BANK_WRITE_AP:
          if (tm_end)
          begin
            st_d = ddr2_cmd_pkg::BANK_CLOSING;                         // see [R9] [R10]
            tm_d = RP_LD;
          end
        ddr2_cmd_pkg::BANK_CLOSING:
          if (go_pre)
            tm_d = RP_LD;  // Last precharge sets the period
          else if (tm_end && bs_end)
            st_d = ddr2_cmd_pkg::BANK_IDLE;                            // see [R7]
      endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        st_q[b]  <= ddr2_cmd_pkg::BANK_IDLE;
        tm_q[b]  <= '0;
        bs_q[b]  <= '0;
        row_q[b] <= ddr2_cmd_pkg::ROW_RST;
      end
      else
      begin
        st_q[b]  <= st_d;
        tm_q[b]  <= tm_d;
        bs_q[b]  <= bs_d;
        row_q[b] <= row_d;
      end
    end

    assign bank_state[b] = st_q[b];
    assign open_row[b]   = row_q[b];
  end

  // ==========================================================
  // Checks on bank 0 and the decoder
  wire b0_sel = (cmd.ba == '0);

  AST_DESELECT_IGNORED: assert property (  // see [R1]
    @(posedge mclk) disable iff (!reset_n)
    cmd.cs_n |=> !cmd_accepted_q && !cmd_illegal_q)
    else $error("deselected cycle produced a command");

  AST_NOP_IGNORED: assert property (  // see [R2]
    @(posedge mclk) disable iff (!reset_n)
    is_nop |=> !cmd_accepted_q && !cmd_illegal_q && $stable(mode_reg))
    else $error("no-operation changed device state");

  AST_ACT_OPENS_ROW: assert property (  // see [R3]
    @(posedge mclk) disable iff (!reset_n)
    (is_act && b0_sel && st_q[0] == ddr2_cmd_pkg::BANK_IDLE && !busy)
      |=> st_q[0] == ddr2_cmd_pkg::BANK_OPENING && row_q[0] == $past(cmd.addr))
    else $error("activate did not open row in bank 0");

  AST_TRCD_TO_ACTIVE: assert property (  // see [R21]
    @(posedge mclk) disable iff (!reset_n)
    (ok_act && b0_sel) |=> (st_q[0] == ddr2_cmd_pkg::BANK_OPENING) [*2]
      ##1 st_q[0] == ddr2_cmd_pkg::BANK_ACTIVE)
    else $error("bank 0 active not exactly tRCD after activate");

  AST_CLOSE_TO_IDLE: assert property (  // see [R7]
    @(posedge mclk) disable iff (!reset_n)
    (st_q[0] == ddr2_cmd_pkg::BANK_CLOSING && tm_q[0] == '0 && bs_q[0] == '0
      && !(ok_pre && (b0_sel || ap_sel))) |=> st_q[0] == ddr2_cmd_pkg::BANK_IDLE)
    else $error("bank 0 did not go idle after precharge");

  AST_READ_STATE: assert property (  // see [R8]
    @(posedge mclk) disable iff (!reset_n)
    (ok_rd && b0_sel && !ap_sel) |=> st_q[0] == ddr2_cmd_pkg::BANK_READ
      && bs_q[0] == RD_BS_LD)
    else $error("read without auto precharge did not enter read state");

  AST_RDAP_PRECHARGE: assert property (  // see [R9]
    @(posedge mclk) disable iff (!reset_n)
    (ok_rd && b0_sel && ap_sel) |=> st_q[0] == ddr2_cmd_pkg::BANK_READ_AP
      ##RD_AP_CYC st_q[0] == ddr2_cmd_pkg::BANK_CLOSING)
    else $error("read auto precharge began at wrong clock");

  AST_WRAP_PRECHARGE: assert property (  // see [R10]
    @(posedge mclk) disable iff (!reset_n)
    (ok_wr && b0_sel && ap_sel) |=> st_q[0] == ddr2_cmd_pkg::BANK_WRITE_AP
      ##WR_AP_CYC st_q[0] == ddr2_cmd_pkg::BANK_CLOSING)
    else $error("write auto precharge began at wrong clock");

  AST_CONCURRENT_AP: assert property (  // see [R11]
    @(posedge mclk) disable iff (!reset_n)
    ((st_q[0] == ddr2_cmd_pkg::BANK_READ_AP || st_q[0] == ddr2_cmd_pkg::BANK_WRITE_AP)
      && tm_q[0] != '0 && is_act && !b0_sel && is_idle[cmd.ba] && !busy)
      |=> cmd_accepted_q && st_q[0] == $past(st_q[0]))
    else $error("auto precharge blocked or disturbed by other bank");

  AST_MODE_LOAD: assert property (  // see [R19]
    @(posedge mclk) disable iff (!reset_n)
    (ok_lm && b0_sel) |=> mode_reg[0] == $past(cmd.addr) && mrd_busy_q)
    else $error("mode register 0 not loaded from address");

endmodule

// ### testbench/ctrl_model.sv
// Behavioural memory controller that drives the command pins of the bank tracker
`timescale 1ns/1ns

module ctrl_model
(
  input  wire logic          mclk,
  output ddr2_cmd_pkg::cmd_s cmd
);
  logic cke_en;

  // ==========================================================
  // Pins at time zero: deselected, clock enable high
  initial
  begin
    cke_en = 1'b1;
    cmd = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: 14'h0000};
  end

  // ==========================================================
  // One command for one edge, then deselect; the other lines flip so that a
  // stale command pattern is never mistaken for a live one
  task automatic issue(input logic [3:0] code, input logic [1:0] bank, input logic [13:0] adr);
    @(posedge mclk);
    cmd <= '{cke: cke_en, cs_n: code[3], ras_n: code[2], cas_n: code[1], we_n: code[0],
             ba: bank, addr: adr};
    @(posedge mclk);
    cmd <= '{cke: cke_en, cs_n: 1'b1, ras_n: ~code[2], cas_n: ~code[1], we_n: ~code[0],
             ba: ~bank, addr: ~adr};
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the bank tracker, driven through the controller model
`timescale 1ns/1ns

module testbench;
  localparam int BL = 4;
  localparam int CL = 5;
  localparam int RD_CYC = CL + BL / 2;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] REFR = 4'h1;
  localparam logic [3:0] MODE_LD = 4'h0;
  localparam logic [3:0] NOP = 4'h7;
  localparam logic [1:0] OK = 2'h2;
  localparam logic [1:0] BAD = 2'h1;
  localparam logic [1:0] NONE = 2'h0;

  logic                                                    mclk;
  logic                                                    reset_n;
  ddr2_cmd_pkg::cmd_s                                      cmd;
  ddr2_cmd_pkg::bank_state_e [ddr2_cmd_pkg::NUM_BANKS-1:0] bank_state;
  logic [3:0][13:0]                                        open_row;
  logic [3:0][13:0]                                        mode_reg;
  logic                                                    ref_busy_q;
  logic                                                    mrd_busy_q;
  logic                                                    cmd_accepted_q;
  logic                                                    cmd_illegal_q;
  int                                                      miscompares;
  int                                                      total_checks;

  ctrl_model ctrl (.mclk(mclk), .cmd(cmd));

  ddr2_bank_tracker #(.BURST_LEN(BL), .CAS_LAT(CL)) dut
  (
    .mclk(mclk), .reset_n(reset_n), .cmd(cmd), .bank_state(bank_state),
    .open_row(open_row), .mode_reg(mode_reg), .ref_busy_q(ref_busy_q),
    .mrd_busy_q(mrd_busy_q), .cmd_accepted_q(cmd_accepted_q), .cmd_illegal_q(cmd_illegal_q)
  );

  // Free-running device clock, 8 ns period
  initial
    mclk = 1'b0;
  always #4 mclk = ~mclk;

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Result pulse stands one cycle, so it is read just after the sampling edge
  task automatic do_cmd(input logic [3:0] code, input logic [1:0] bank, input logic [13:0] adr,
                        input logic [1:0] res);
    ctrl.issue(code, bank, adr);
    #1;
    check({cmd_accepted_q, cmd_illegal_q}, res);
  endtask

  // Bounded wait for a bank state; running out of cycles shows as a mismatch
  task automatic wait_state(input int b, input ddr2_cmd_pkg::bank_state_e st, input int maxc);
    int n;
    n = 0;
    while (bank_state[b] !== st && n < maxc)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(bank_state[b], st);
  endtask

  task automatic results();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int b = 0; b < 4; b++)
    begin
      check(bank_state[b], ddr2_cmd_pkg::BANK_IDLE);
      check(mode_reg[b], ddr2_cmd_pkg::MODE_RST);
    end
    check({ref_busy_q, mrd_busy_q, cmd_accepted_q, cmd_illegal_q}, 4'h0);
  endtask

  // Deselect carrying an activate pattern, a plain no-op, and a clock-enable gap
  task automatic t_inhibit();
    do_cmd(4'hb, 2'h0, 14'h0001, NONE);
    do_cmd(NOP, 2'h0, 14'h0001, NONE);
    ctrl.cke_en <= 1'b0;
    do_cmd(ACT, 2'h0, 14'h0001, NONE);
    ctrl.cke_en <= 1'b1;
    do_cmd(ACT, 2'h0, 14'h0001, NONE);
    check(bank_state[0], ddr2_cmd_pkg::BANK_IDLE);
  endtask

  task automatic t_mode();
    for (int b = 0; b < 4; b++)
    begin
      do_cmd(MODE_LD, 2'(b), 14'h0123 + 14'(b), OK);
      check(mode_reg[b], 14'h0123 + 14'(b));
      check(mrd_busy_q, 1'b1);
      do_cmd(NOP, 2'h0, 14'h0000, NONE);
    end
    for (int b = 0; b < 4; b++)
      check(mode_reg[b], 14'h0123 + 14'(b));
  endtask

  // Second bank opened while the first is still opening
  task automatic t_open();
    do_cmd(ACT, 2'h0, 14'h1a5a, OK);
    do_cmd(ACT, 2'h1, 14'h2c3c, OK);
    check(bank_state[1], ddr2_cmd_pkg::BANK_OPENING);
    check(open_row[0], 14'h1a5a);
    check(open_row[1], 14'h2c3c);
    wait_state(0, ddr2_cmd_pkg::BANK_ACTIVE, 3);
    wait_state(1, ddr2_cmd_pkg::BANK_ACTIVE, 3);
    do_cmd(ACT, 2'h0, 14'h0777, BAD);
    check(open_row[0], 14'h1a5a);
    do_cmd(RD, 2'h3, 14'h0000, BAD);
  endtask

  // Bursts without auto precharge; the write waits for the read to finish
  task automatic t_burst();
    do_cmd(RD, 2'h0, 14'h0008, OK);
    check(bank_state[0], ddr2_cmd_pkg::BANK_READ);
    wait_state(0, ddr2_cmd_pkg::BANK_ACTIVE, RD_CYC);
    do_cmd(WR, 2'h1, 14'h0010, OK);
    check(bank_state[1], ddr2_cmd_pkg::BANK_WRITE);
    wait_state(1, ddr2_cmd_pkg::BANK_ACTIVE, RD_CYC);
  endtask

  // Both auto precharge kinds on bank 0; other banks are served during the
  // access period, which is what concurrent auto precharge has to allow
  task automatic t_auto();
    do_cmd(RD, 2'h0, 14'h0400, OK);
    check(bank_state[0], ddr2_cmd_pkg::BANK_READ_AP);
    do_cmd(ACT, 2'h2, 14'h0042, OK);
    wait_state(0, ddr2_cmd_pkg::BANK_CLOSING, 3);
    wait_state(0, ddr2_cmd_pkg::BANK_IDLE, RD_CYC);
    do_cmd(ACT, 2'h0, 14'h0101, OK);
    wait_state(0, ddr2_cmd_pkg::BANK_ACTIVE, 3);
    do_cmd(WR, 2'h0, 14'h0404, OK);
    check(bank_state[0], ddr2_cmd_pkg::BANK_WRITE_AP);
    do_cmd(ACT, 2'h3, 14'h0333, OK);
    do_cmd(PRE, 2'h2, 14'h0000, OK);
    check(bank_state[2], ddr2_cmd_pkg::BANK_CLOSING);
    check(bank_state[0], ddr2_cmd_pkg::BANK_WRITE_AP);
    wait_state(0, ddr2_cmd_pkg::BANK_CLOSING, 9);
    wait_state(0, ddr2_cmd_pkg::BANK_IDLE, 4);
  endtask

  // Refresh refused with open rows, then taken once all banks are idle
  task automatic t_refresh();
    do_cmd(ACT, 2'h3, 14'h0333, BAD);
    wait_state(3, ddr2_cmd_pkg::BANK_ACTIVE, 3);
    do_cmd(REFR, 2'h0, 14'h0000, BAD);
    do_cmd(PRE, 2'h0, 14'h0400, OK);
    wait_state(3, ddr2_cmd_pkg::BANK_IDLE, 4);
    wait_state(1, ddr2_cmd_pkg::BANK_IDLE, 4);
    wait_state(2, ddr2_cmd_pkg::BANK_IDLE, 4);
    do_cmd(REFR, 2'h0, 14'h0000, OK);
    check(ref_busy_q, 1'b1);
    do_cmd(ACT, 2'h0, 14'h0005, BAD);
    repeat (ddr2_cmd_pkg::T_RFC_CYC) @(posedge mclk);
    do_cmd(ACT, 2'h0, 14'h0005, OK);
  endtask

  // ==========================================================
  // Main sequence and watchdog; about 120 cycles are expected
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    reset_n = 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_inhibit();
    t_mode();
    t_open();
    t_burst();
    t_auto();
    t_refresh();
    results();
  end

  initial
  begin
    #(8 * 3000);
    miscompares++;
    results();
  end
endmodule
